// file: sample_queue_pkg.sv
// constants and register map of the temperature sample queue
//
// Summary of operation
// - first byte t15..t8, second t7..t0
// - flag at thirty-two minus watermark words
// - flag, enable, pin mode three drive pin
// - full push overwrites or discards per policy
// - type low: reassert every stored sample while high
// - type high: assert only on fresh condition
// - select low: data read keeps flag
// - select high: data read clears flag
// - flush empties queue, zeroes indices, self-clears
// - indices advance by one and wrap
// - lost count saturates, clears on pop
// - queued count follows pushes and pops

package sample_queue_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] off_event_flags = 8'h00;
	localparam logic [7:0] off_event_enables = 8'h01;
	localparam logic [7:0] off_queue_write_index = 8'h04;
	localparam logic [7:0] off_queue_read_index = 8'h05;
	localparam logic [7:0] off_lost_word_count = 8'h06;
	localparam logic [7:0] off_queued_word_count = 8'h07;
	localparam logic [7:0] off_queue_read_port = 8'h08;
	localparam logic [7:0] off_queue_watermark_cfg = 8'h09;
	localparam logic [7:0] off_queue_policy_cfg = 8'h0a;

	// ****************************************
	// fields, sizes and reset values
	// ****************************************
	localparam int almost_full_bit = 7;
	localparam int rollover_bit = 1;
	localparam int flag_type_bit = 2;
	localparam int clear_select_bit = 3;
	localparam int flush_bit = 4;
	localparam logic [7:0] enables_mask = 8'h87;
	localparam logic [5:0] queue_depth = 6'h20;
	localparam logic [4:0] lost_count_max = 5'h1f;
	localparam logic [1:0] pin_mode_interrupt = 2'h3;
	localparam logic [4:0] index_reset = 5'h00;
	localparam logic [7:0] reg_reset = 8'h00;

endpackage

// file: temperature_sample_fifo.sv
// temperature sample queue with register access and almost-full pin
`timescale 1ns/1ps
`default_nettype none

module temperature_sample_fifo
	import sample_queue_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// samples from the conversion process
	input wire logic sample_valid,
	input wire logic [15:0] sample_data,
	// register access from the serial engine
	input wire logic burst_start,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// pin setup and pin
	input wire logic [1:0] pin0_function_select,
	output logic general_pin_0
);

	// ****************************************
	// storage
	// ****************************************
	logic [15:0] mem [0:31];
	logic [4:0] queue_write_index;
	logic [4:0] queue_read_index;
	logic [4:0] lost_word_count;
	logic [5:0] queued_word_count;
	logic second_byte;
	logic almost_full;
	logic cond_seen;
	logic [7:0] event_enables;
	logic [4:0] watermark;
	logic overwrite_when_full;
	logic flag_type;
	logic clear_flag_on_data_read;

	logic [4:0] next_write_index;
	logic [4:0] next_read_index;
	logic [4:0] next_lost;
	logic [5:0] next_count;
	logic next_second_byte;
	logic next_almost_full;
	logic next_cond_seen;
	logic [7:0] next_enables;
	logic [4:0] next_watermark;
	logic next_overwrite;
	logic next_flag_type;
	logic next_clear_select;
	logic [7:0] next_rdata;
	logic next_pin;

	logic rd_data;
	logic rd_status;
	logic wr_policy;
	logic flush;
	logic rd_index_wr;
	logic pop;
	logic full_now;
	logic stored;
	logic cond;
	logic [5:0] threshold;
	logic [15:0] head_word;

	assign head_word = mem[queue_read_index];
	assign rd_data = reg_rd && (reg_addr == off_queue_read_port);
	assign rd_status = reg_rd && (reg_addr == off_event_flags);
	assign wr_policy = reg_wr && (reg_addr == off_queue_policy_cfg);
	assign flush = wr_policy && reg_wdata[flush_bit];
	assign rd_index_wr = reg_wr && (reg_addr == off_queue_read_index);
	// a word leaves only on its second byte, and never from empty
	assign pop = rd_data && second_byte && (queued_word_count != 6'h00);
	assign full_now = (queued_word_count == queue_depth) && !pop;
	// with discard policy a push into a full queue is dropped and only bumps the lost count
	assign stored = sample_valid && (!full_now || overwrite_when_full);
	assign threshold = queue_depth - {1'b0, watermark};

	// ****************************************
	// queue indices and counters
	// ****************************************
	always_comb begin
		next_write_index = queue_write_index;
		next_read_index = queue_read_index;
		next_lost = lost_word_count;
		next_count = queued_word_count;
		next_second_byte = second_byte;
		if (burst_start) begin
			next_second_byte = 1'b0;
		end else if (rd_data && queued_word_count != 6'h00) begin
			next_second_byte = !second_byte;
		end
		if (pop) begin
			next_read_index = queue_read_index + 5'h01;
			next_lost = index_reset;
			next_count = queued_word_count - 6'h01;
		end
		if (sample_valid && full_now) begin
			if (lost_word_count != lost_count_max) begin
				next_lost = lost_word_count + 5'h01;
			end
			if (overwrite_when_full) begin
				next_read_index = queue_read_index + 5'h01;
			end
		end
		if (stored) begin
			next_write_index = queue_write_index + 5'h01;
			if (!full_now) begin
				next_count = next_count + 6'h01;
			end
		end
		if (rd_index_wr) begin
			// reread support: count follows the new distance
			next_read_index = reg_wdata[4:0];
			next_count = {1'b0, queue_write_index - reg_wdata[4:0]};
		end
		if (flush) begin
			next_write_index = index_reset;
			next_read_index = index_reset;
			next_lost = index_reset;
			next_count = 6'h00;
			next_second_byte = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			queue_write_index <= index_reset;
			queue_read_index <= index_reset;
			lost_word_count <= index_reset;
			queued_word_count <= 6'h00;
			second_byte <= 1'b0;
		end else begin
			queue_write_index <= next_write_index;
			queue_read_index <= next_read_index;
			lost_word_count <= next_lost;
			queued_word_count <= next_count;
			second_byte <= next_second_byte;
		end
	end

	// sample array carries no reset; contents are meaningless until pushed
	always_ff @(posedge ref_clk) begin
		if (stored && !flush) begin
			mem[queue_write_index] <= sample_data;
		end
	end

	// ****************************************
	// almost-full flag and pin
	// ****************************************
	always_comb begin
		cond = stored && !flush && (next_count >= threshold);
		next_cond_seen = cond_seen;
		next_almost_full = almost_full;
		if (rd_status || (rd_data && clear_flag_on_data_read)) begin
			next_almost_full = 1'b0;
		end
		if (flush || (next_count < threshold)) begin
			next_cond_seen = 1'b0;
		end
		if (cond) begin
			next_cond_seen = 1'b1;
			if (!flag_type || !cond_seen) begin
				// a new event wins over a clear in the same cycle
				next_almost_full = 1'b1;
			end
		end
		next_pin = almost_full && event_enables[almost_full_bit]
			&& (pin0_function_select == pin_mode_interrupt);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			almost_full <= 1'b0;
			cond_seen <= 1'b0;
			general_pin_0 <= 1'b0;
		end else begin
			almost_full <= next_almost_full;
			cond_seen <= next_cond_seen;
			general_pin_0 <= next_pin;
		end
	end

	// ****************************************
	// configuration and read data
	// ****************************************
	always_comb begin
		next_enables = event_enables;
		next_watermark = watermark;
		next_overwrite = overwrite_when_full;
		next_flag_type = flag_type;
		next_clear_select = clear_flag_on_data_read;
		if (reg_wr && reg_addr == off_event_enables) begin
			next_enables = reg_wdata & enables_mask;
		end
		if (reg_wr && reg_addr == off_queue_watermark_cfg) begin
			next_watermark = reg_wdata[4:0];
		end
		if (wr_policy) begin
			next_overwrite = reg_wdata[rollover_bit];
			next_flag_type = reg_wdata[flag_type_bit];
			next_clear_select = reg_wdata[clear_select_bit];
		end
		next_rdata = reg_rdata;
		if (reg_rd) begin
			unique case (reg_addr)
				off_event_flags: next_rdata = {almost_full, 7'h00};
				off_event_enables: next_rdata = event_enables;
				off_queue_write_index: next_rdata = {3'h0, queue_write_index};
				off_queue_read_index: next_rdata = {3'h0, queue_read_index};
				off_lost_word_count: next_rdata = {3'h0, lost_word_count};
				off_queued_word_count: next_rdata = {2'h0, queued_word_count};
				off_queue_read_port: next_rdata = second_byte ?
					head_word[7:0] : head_word[15:8];
				off_queue_watermark_cfg: next_rdata = {3'h0, watermark};
				// flush reads back zero since it clears itself at once
				off_queue_policy_cfg: next_rdata = {4'h0, clear_flag_on_data_read,
					flag_type, overwrite_when_full, 1'b0};
				default: next_rdata = reg_reset;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			event_enables <= reg_reset;
			watermark <= index_reset;
			overwrite_when_full <= 1'b0;
			flag_type <= 1'b0;
			clear_flag_on_data_read <= 1'b0;
			reg_rdata <= reg_reset;
		end else begin
			event_enables <= next_enables;
			watermark <= next_watermark;
			overwrite_when_full <= next_overwrite;
			flag_type <= next_flag_type;
			clear_flag_on_data_read <= next_clear_select;
			reg_rdata <= next_rdata;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	logic quiet;
	assign quiet = !flush && !rd_index_wr;

	sequence s_first_byte;
		rd_data && !second_byte && queued_word_count != 6'h00 && quiet;
	endsequence

	sequence s_second_byte;
		rd_data && !burst_start && quiet && !sample_valid;
	endsequence

	property p_byte_order;
		@(posedge ref_clk) disable iff (!nrst)
		rd_data && !second_byte |=> reg_rdata == $past(head_word[15:8]);
	endproperty
	a_byte_order: assert property (p_byte_order) else $error("high byte not first");

	property p_pop_after_pair;
		@(posedge ref_clk) disable iff (!nrst)
		s_first_byte ##1 s_second_byte |=>
			queued_word_count == $past(queued_word_count) - 6'h01;
	endproperty
	a_pop_after_pair: assert property (p_pop_after_pair) else $error("pair did not pop");

	property p_watermark;
		@(posedge ref_clk) disable iff (!nrst)
		cond && !flag_type |=> almost_full;
	endproperty
	a_watermark: assert property (p_watermark) else $error("flag not set at mark");

	property p_pin;
		@(posedge ref_clk) disable iff (!nrst)
		almost_full && event_enables[7] && pin0_function_select == 2'h3
			|=> general_pin_0;
	endproperty
	a_pin: assert property (p_pin) else $error("pin not raised");

	property p_discard;
		@(posedge ref_clk) disable iff (!nrst)
		sample_valid && full_now && !overwrite_when_full && quiet
			|=> $stable(queue_write_index) && queued_word_count == 6'h20;
	endproperty
	a_discard: assert property (p_discard) else $error("full push not dropped");

	property p_overwrite;
		@(posedge ref_clk) disable iff (!nrst)
		sample_valid && full_now && overwrite_when_full && quiet
			|=> queue_read_index == $past(queue_read_index) + 5'h01
			&& queued_word_count == 6'h20;
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("overwrite lost read index");

	property p_fresh_only;
		@(posedge ref_clk) disable iff (!nrst)
		flag_type && cond_seen && !almost_full && next_count >= threshold
			&& quiet |=> !almost_full;
	endproperty
	a_fresh_only: assert property (p_fresh_only) else $error("flag reasserted");

	property p_keep_on_data;
		@(posedge ref_clk) disable iff (!nrst)
		almost_full && !clear_flag_on_data_read && !rd_status |=> almost_full;
	endproperty
	a_keep_on_data: assert property (p_keep_on_data) else $error("flag lost");

	property p_clear_on_data;
		@(posedge ref_clk) disable iff (!nrst)
		rd_data && clear_flag_on_data_read && !cond |=> !almost_full;
	endproperty
	a_clear_on_data: assert property (p_clear_on_data) else $error("flag kept");

	property p_flush;
		@(posedge ref_clk) disable iff (!nrst)
		flush |=> queued_word_count == 6'h00 && queue_write_index == 5'h00
			&& queue_read_index == 5'h00 && lost_word_count == 5'h00;
	endproperty
	a_flush: assert property (p_flush) else $error("flush incomplete");

	property p_lost_saturate;
		@(posedge ref_clk) disable iff (!nrst)
		lost_word_count == 5'h1f && sample_valid && full_now && quiet
			|=> lost_word_count == 5'h1f;
	endproperty
	a_lost_saturate: assert property (p_lost_saturate) else $error("lost count wrapped");

	property p_push_count;
		@(posedge ref_clk) disable iff (!nrst)
		sample_valid && !full_now && !pop && quiet
			|=> queued_word_count == $past(queued_word_count) + 6'h01;
	endproperty
	a_push_count: assert property (p_push_count) else $error("count missed push");

endmodule
`default_nettype wire

// file: queue_master_model.sv
// register-bus master model that reads and writes the sample queue
`timescale 1ns/1ps
`default_nettype none

module queue_master_model
	import sample_queue_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// register access towards the queue
	output logic burst_start,
	output logic reg_rd,
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		burst_start = 1'b0;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// idle lines show the inverse so stale values never pass for live ones
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask

	// one word is two back-to-back data reads after a burst start
	task automatic burst(output logic [15:0] w);
		@(negedge ref_clk);
		burst_start = 1'b1;
		@(negedge ref_clk);
		burst_start = 1'b0;
		reg_rd = 1'b1;
		reg_addr = off_queue_read_port;
		@(negedge ref_clk);
		w[15:8] = reg_rdata;
		@(negedge ref_clk);
		w[7:0] = reg_rdata;
		reg_rd = 1'b0;
		reg_addr = 8'hf7;
	endtask
endmodule
`default_nettype wire

// file: temperature_sample_fifo_bench.sv
// self-checking bench of the temperature sample queue
`timescale 1ns/1ps
`default_nettype none

module temperature_sample_fifo_bench;
	import sample_queue_pkg::*;
	logic ref_clk, nrst, sample_valid, burst_start, reg_rd, reg_wr;
	logic [15:0] sample_data;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, lost, cnt;
	logic [1:0] pin0_function_select;
	logic general_pin_0;
	int mismatches;
	int checked;
	logic [15:0] sent[$];
	logic [15:0] keep[$];
	logic [15:0] w;
	logic [7:0] regs[9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06,
		8'h07, 8'h09, 8'h0a};

	temperature_sample_fifo dut (.ref_clk(ref_clk), .nrst(nrst),
		.sample_valid(sample_valid), .sample_data(sample_data),
		.burst_start(burst_start), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.pin0_function_select(pin0_function_select),
		.general_pin_0(general_pin_0));
	queue_master_model master (.ref_clk(ref_clk), .burst_start(burst_start),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	always #20 ref_clk = ~ref_clk;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] avail(logic [7:0] l, logic [7:0] c);
		return (l == 8'h00) ? c : 8'h20;
	endfunction
	function automatic logic [7:0] diff(logic [7:0] a, logic [7:0] b);
		return (a - b) & 8'h1f;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		master.rd(a, d);
		chk(d, exp);
	endtask
	task automatic push(input logic [15:0] v);
		@(negedge ref_clk);
		sample_valid = 1'b1;
		sample_data = v;
		@(negedge ref_clk);
		sample_valid = 1'b0;
		sample_data = ~v;
	endtask
	task automatic fill(input int n);
		logic [15:0] v;
		for (int k = 0; k < n; k++) begin
			v = 16'($urandom);
			push(v);
			sent.push_back(v);
		end
	endtask
	task automatic pop_chk();
		master.burst(w);
		chk(w[15:8], sent[0][15:8]);
		chk(w[7:0], sent[0][7:0]);
		void'(sent.pop_front());
	endtask
	task automatic flush(input logic [7:0] cfg);
		master.wr(off_queue_policy_cfg, 8'h10);
		master.wr(off_queue_policy_cfg, cfg);
		sent.delete();
	endtask
	task results();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		mismatches++;
		results();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		sample_valid = 1'b0;
		sample_data = 16'h0000;
		pin0_function_select = pin_mode_interrupt;
		mismatches = 0;
		checked = 0;
		void'($urandom(32'heec8));
		repeat (3) @(negedge ref_clk);
		nrst = 1'b1;
		foreach (regs[k]) rchk(regs[k], reg_reset);
		master.wr(off_event_enables, 8'hff);
		rchk(off_event_enables, enables_mask);
		master.wr(8'h02, 8'hff);
		rchk(8'h02, 8'h00);
		$display("test reset done");
		// partial queue, unpaired byte, empty read, reread
		fill(5);
		master.wr(off_queue_write_index, 8'h1c);
		rchk(off_queue_write_index, 8'h05);
		master.rd(off_lost_word_count, lost);
		master.rd(off_queued_word_count, cnt);
		chk(avail(lost, cnt), 8'h05);
		master.rd(off_queue_write_index, d);
		master.rd(off_queue_read_index, cnt);
		chk(diff(d, cnt), 8'h05);
		master.rd(off_queue_read_port, d);
		rchk(off_queued_word_count, 8'h05);
		keep = sent;
		repeat (5) pop_chk();
		rchk(off_queue_read_index, 8'h05);
		master.burst(w);
		rchk(off_queued_word_count, 8'h00);
		rchk(off_queue_read_index, 8'h05);
		master.wr(off_queue_read_index, 8'h03);
		rchk(off_queued_word_count, 8'h02);
		master.burst(w);
		chk(w[15:8], keep[3][15:8]);
		chk(w[7:0], keep[3][7:0]);
		$display("test partial done");
		// full queue, discard policy, lost count saturation
		flush(8'h00);
		foreach (regs[k]) if (k > 2) rchk(regs[k], 8'h00);
		fill(32);
		repeat (3) push(16'($urandom));
		rchk(off_lost_word_count, 8'h03);
		rchk(off_queue_write_index, 8'h00);
		rchk(off_queued_word_count, 8'h20);
		master.rd(off_lost_word_count, lost);
		master.rd(off_queued_word_count, cnt);
		chk(avail(lost, cnt), 8'h20);
		pop_chk();
		rchk(off_lost_word_count, 8'h00);
		repeat (34) push(16'($urandom));
		rchk(off_lost_word_count, 8'h1f);
		$display("test discard done");
		// rollover keeps the newest thirty-two
		flush(8'h02);
		fill(34);
		repeat (2) void'(sent.pop_front());
		rchk(off_queue_read_index, 8'h02);
		rchk(off_queue_write_index, 8'h02);
		rchk(off_queued_word_count, 8'h20);
		pop_chk();
		// flush leaves the flag alone, so the status read clears it here
		rchk(off_event_flags, 8'h80);
		$display("test rollover done");
		// watermark, pin, per-sample flag, data read keeps flag
		flush(8'h00);
		master.wr(off_queue_watermark_cfg, 8'h02);
		master.wr(off_event_enables, 8'h80);
		fill(29);
		rchk(off_event_flags, 8'h00);
		chk(general_pin_0, 1'b0);
		fill(1);
		@(negedge ref_clk);
		chk(general_pin_0, 1'b1);
		pop_chk();
		rchk(off_event_flags, 8'h80);
		rchk(off_event_flags, 8'h00);
		fill(2);
		rchk(off_event_flags, 8'h80);
		fill(1);
		pin0_function_select = 2'($urandom_range(2, 0));
		repeat (2) @(negedge ref_clk);
		chk(general_pin_0, 1'b0);
		pin0_function_select = pin_mode_interrupt;
		rchk(off_event_flags, 8'h80);
		$display("test level flag done");
		// fresh-only flag and data read clear
		flush(8'h04);
		fill(30);
		rchk(off_event_flags, 8'h80);
		fill(1);
		rchk(off_event_flags, 8'h00);
		master.wr(off_queue_policy_cfg, 8'h0c);
		repeat (2) pop_chk();
		fill(1);
		@(negedge ref_clk);
		chk(general_pin_0, 1'b1);
		master.burst(w);
		rchk(off_event_flags, 8'h00);
		$display("test fresh flag done");
		results();
	end
endmodule
`default_nettype wire
